// file: hdl/vicr_consts.vh
// Constants for the video input configuration register bank.
`ifndef VICR_CONSTS_VH
`define VICR_CONSTS_VH
// ===================================================================
// Register offsets (byte addresses are four times the index)
`define VICR_IDX_ROUTE      6'h00
`define VICR_IDX_MODE       6'h01
`define VICR_IDX_ENH        6'h02
`define VICR_IDX_STATUS     6'h03
`define VICR_ADDR_LSB       2
// ===================================================================
// Reset values
`define VICR_RST_ROUTE      8'h00
`define VICR_RST_MODE       8'h00
`define VICR_RST_ENH        8'h04
`define VICR_RST_PEAK       3'h4
// ===================================================================
// Field positions
`define VICR_ROUTE_LO       3
`define VICR_ROUTE_HI       0
`define VICR_STD_HI         7
`define VICR_STD_LO         4
`define VICR_QUAL_HI        1
`define VICR_QUAL_LO        0
`define VICR_SQPIX_BIT      2
`define VICR_DIFF_BIT       3
`define VICR_FSC4_BIT       4
`define VICR_STUDIO_BIT     5
`define VICR_AUTODIS_BIT    7
`define VICR_PEAK_HI        2
`define VICR_PEAK_LO        0
`define VICR_CORE_HI        4
`define VICR_CORE_LO        3
// ===================================================================
// Codes
`define VICR_ROUTE_YC_FIRST 4'h6
`define VICR_ROUTE_CP_FIRST 4'h9
`define VICR_ROUTE_LAST     4'ha
`define VICR_STD_FIXED_LO   4'h4
`define VICR_STD_LAST       4'hd
`define VICR_FMT_CVBS       2'h0
`define VICR_FMT_YC         2'h1
`define VICR_FMT_COMP       2'h2
`define VICR_FMT_BAD        2'h3
`define VICR_RESP_OKAY      2'h0
`define VICR_RESP_SLVERR    2'h2
`endif

// file: hdl/vicr_regs.v
// Video input configuration register bank with AXI4-Lite slave.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "vicr_consts.vh"

// ===================================================================
module vicr_regs (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  output reg  [5:0]  luma_input_sel_out,
  output reg  [5:0]  chroma_u_input_sel_out,
  output reg  [5:0]  chroma_v_input_sel_out,
  output reg  [1:0]  input_format_out,
  output reg         std_auto_detect_out,
  output reg         std_pal_n_pair_out,
  output reg  [3:0]  video_standard_choice_out,
  output reg         pedestal_out,
  output reg  [1:0]  source_quality_class_out,
  output reg         square_pixel_enable_out,
  output reg         differential_input_enable_out,
  output reg         four_subcarrier_rate_mode_out,
  output reg         studio_input_enable_out,
  output reg         reacquire_pulse_out,
  output reg  [2:0]  luma_peaking_gain_out,
  output reg  [5:0]  luma_core_threshold_out
);

  // =================================================================
  // Register storage and write channel
  reg  [7:0] route_q;
  reg  [7:0] mode_q;
  reg  [7:0] enh_q;
  reg        aw_held_q;
  reg        w_held_q;
  reg  [7:0] aw_addr_q;
  reg  [7:0] w_data_q;
  reg        w_lane_q;
  reg  [7:0] reacq_count_q;
  wire       aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire       w_take  = s_axi_wvalid_in & s_axi_wready_out;
  wire       do_write = aw_held_q & w_held_q & ~s_axi_bvalid_out;
  wire [5:0] wr_idx   = aw_addr_q[7:`VICR_ADDR_LSB];
  wire       wr_hit   = (wr_idx == `VICR_IDX_ROUTE) |
                        (wr_idx == `VICR_IDX_MODE)  |
                        (wr_idx == `VICR_IDX_ENH);
  wire [3:0] new_route = w_data_q[`VICR_ROUTE_LO:`VICR_ROUTE_HI];
  wire       store    = do_write & w_lane_q;
  wire       route_we = store & (wr_idx == `VICR_IDX_ROUTE);
  wire       mode_we  = store & (wr_idx == `VICR_IDX_MODE);
  wire       enh_we   = store & (wr_idx == `VICR_IDX_ENH);
  wire       route_chg = route_we &
                         (new_route !=
                          route_q[`VICR_ROUTE_LO:`VICR_ROUTE_HI]);
  // The disable bit is taken before the write that may change it.
  wire       reacq_go  = route_chg & ~mode_q[`VICR_AUTODIS_BIT];

  // Address and data are accepted in either order and held.
  // A write with byte lane 0 off is acknowledged but stores nothing.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_held_q         <= 1'b0;
      w_held_q          <= 1'b0;
      aw_addr_q         <= 8'h00;
      w_data_q          <= 8'h00;
      w_lane_q          <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `VICR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_q         <= 1'b1;
        aw_addr_q         <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (w_take) begin
        w_held_q         <= 1'b1;
        w_data_q         <= s_axi_wdata_in[7:0];
        w_lane_q         <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (do_write) begin
        aw_held_q        <= 1'b0;
        w_held_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? `VICR_RESP_OKAY : `VICR_RESP_SLVERR;
      end
      // Readies return only after the response, so one write is in flight.
      if (s_axi_bvalid_out & s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // =================================================================
  // Configuration registers
  // Reserved bits are stored as written; software keeps them zero.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      route_q <= `VICR_RST_ROUTE;
      mode_q  <= `VICR_RST_MODE;
      enh_q   <= `VICR_RST_ENH;
    end else begin
      if (route_we) begin
        route_q <= w_data_q;
      end
      if (mode_we) begin
        mode_q <= w_data_q;
      end
      if (enh_we) begin
        enh_q <= w_data_q;
      end
    end
  end

  // =================================================================
  // Reacquire event counter
  // Counts reacquire events so software can see them took effect.
  // It wraps silently; software compares two reads to spot new events.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      reacq_count_q <= 8'h00;
    end else if (reacq_go) begin
      reacq_count_q <= reacq_count_q + 8'h01;
    end
  end

  // =================================================================
  // Read channel
  wire [5:0]  rd_idx = s_axi_araddr_in[7:`VICR_ADDR_LSB];
  reg  [31:0] rd_data_d;
  reg  [1:0]  rd_resp_d;

  // The word is chosen beside the handshake so the flop only captures.
  // Unmapped indices read as zero with an error response.
  always @* begin
    rd_data_d = 32'h00000000;
    rd_resp_d = `VICR_RESP_OKAY;
    case (rd_idx)
      `VICR_IDX_ROUTE:  rd_data_d = {24'h000000, route_q};
      `VICR_IDX_MODE:   rd_data_d = {24'h000000, mode_q};
      `VICR_IDX_ENH:    rd_data_d = {24'h000000, enh_q};
      `VICR_IDX_STATUS: rd_data_d = {22'h000000, input_format_out,
                                     reacq_count_q};
      default:          rd_resp_d = `VICR_RESP_SLVERR;
    endcase
  end

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `VICR_RESP_OKAY;
    end else if (s_axi_arvalid_in & s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_data_d;
      s_axi_rresp_out   <= rd_resp_d;
    end else if (s_axi_rvalid_out & s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // =================================================================
  // Decoding of fields into datapath controls
  reg  [5:0] luma_d;
  reg  [5:0] cu_d;
  reg  [5:0] cv_d;
  reg  [1:0] fmt_d;
  reg  [5:0] core_d;
  wire [3:0] route = route_q[`VICR_ROUTE_LO:`VICR_ROUTE_HI];
  wire [3:0] std   = route_q[`VICR_STD_HI:`VICR_STD_LO];

  always @* begin
    luma_d = 6'h00;
    cu_d   = 6'h00;
    cv_d   = 6'h00;
    fmt_d  = `VICR_FMT_BAD;
    if (route < `VICR_ROUTE_YC_FIRST) begin
      luma_d = 6'h01 << route;
      fmt_d  = `VICR_FMT_CVBS;
    end else if (route < `VICR_ROUTE_CP_FIRST) begin
      luma_d = 6'h01 << (route - `VICR_ROUTE_YC_FIRST);
      cu_d   = 6'h08 << (route - `VICR_ROUTE_YC_FIRST);
      fmt_d  = `VICR_FMT_YC;
    end else if (route == `VICR_ROUTE_CP_FIRST) begin
      luma_d = 6'h01;
      cu_d   = 6'h08;
      cv_d   = 6'h10;
      fmt_d  = `VICR_FMT_COMP;
    end else if (route == `VICR_ROUTE_LAST) begin
      luma_d = 6'h02;
      cu_d   = 6'h04;
      cv_d   = 6'h20;
      fmt_d  = `VICR_FMT_COMP;
    end
    case (enh_q[`VICR_CORE_HI:`VICR_CORE_LO])
      2'h1:    core_d = 6'h08;
      2'h2:    core_d = 6'h10;
      2'h3:    core_d = 6'h20;
      default: core_d = 6'h00;
    endcase
  end

  // =================================================================
  // Registered routing controls
  // Every control lags its register by one clock.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      luma_input_sel_out     <= 6'h00;
      chroma_u_input_sel_out <= 6'h00;
      chroma_v_input_sel_out <= 6'h00;
      input_format_out       <= `VICR_FMT_CVBS;
    end else begin
      luma_input_sel_out     <= luma_d;
      chroma_u_input_sel_out <= cu_d;
      chroma_v_input_sel_out <= cv_d;
      input_format_out       <= fmt_d;
    end
  end

  // =================================================================
  // Registered standard controls
  // The 4x subcarrier mode is honoured only for the auto-detect and NTSC standards (codes 0 to 7).
  wire       std_auto = (std < `VICR_STD_FIXED_LO);
  wire       std_ntsc = std_auto | (std[3:2] == 2'h1);

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      std_auto_detect_out           <= 1'b0;
      std_pal_n_pair_out            <= 1'b0;
      video_standard_choice_out     <= 4'h0;
      pedestal_out                  <= 1'b0;
      four_subcarrier_rate_mode_out <= 1'b0;
    end else begin
      std_auto_detect_out       <= std_auto;
      std_pal_n_pair_out        <= std_auto & std[1];
      video_standard_choice_out <= std;
      pedestal_out              <= std[0] &
                                   (std <= `VICR_STD_LAST);
      four_subcarrier_rate_mode_out <= mode_q[`VICR_FSC4_BIT] &
                                       std_ntsc;
    end
  end

  // =================================================================
  // Registered mode and enhancement controls
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      source_quality_class_out      <= 2'h0;
      square_pixel_enable_out       <= 1'b0;
      differential_input_enable_out <= 1'b0;
      studio_input_enable_out       <= 1'b0;
      reacquire_pulse_out           <= 1'b0;
      luma_peaking_gain_out         <= `VICR_RST_PEAK;
      luma_core_threshold_out       <= 6'h00;
    end else begin
      source_quality_class_out <=
        mode_q[`VICR_QUAL_HI:`VICR_QUAL_LO];
      square_pixel_enable_out <= mode_q[`VICR_SQPIX_BIT];
      differential_input_enable_out <= mode_q[`VICR_DIFF_BIT];
      studio_input_enable_out <= mode_q[`VICR_STUDIO_BIT];
      reacquire_pulse_out <= reacq_go;
      luma_peaking_gain_out <= enh_q[`VICR_PEAK_HI:`VICR_PEAK_LO];
      luma_core_threshold_out <= core_d;
    end
  end

endmodule // vicr_regs

// file: verification/vicr_regs_asserts.sv
// Checker for the video input configuration register bank.
`timescale 1ns/10ps
// ===================================================================
// Checker
module vicr_regs_asserts (
  input wire       clk_in,
  input wire       resetn_in,
  input wire [5:0] luma_input_sel_out,
  input wire [5:0] chroma_u_input_sel_out,
  input wire [5:0] chroma_v_input_sel_out,
  input wire [1:0] input_format_out,
  input wire       std_auto_detect_out,
  input wire       std_pal_n_pair_out,
  input wire [3:0] video_standard_choice_out,
  input wire       pedestal_out,
  input wire       four_subcarrier_rate_mode_out,
  input wire       reacquire_pulse_out,
  input wire [5:0] luma_core_threshold_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_cvbs_no_chroma: assert property (
    input_format_out == 2'h0 |-> (chroma_u_input_sel_out |
    chroma_v_input_sel_out) == 6'h00) else $error("chroma on composite");
  a_yc_pair_map: assert property (
    input_format_out == 2'h1 |-> luma_input_sel_out != 6'h00 &&
    chroma_u_input_sel_out == (luma_input_sel_out << 3) &&
    chroma_v_input_sel_out == 6'h00) else $error("bad luma chroma pair");
  a_comp_triplet: assert property (
    input_format_out == 2'h2 |-> {luma_input_sel_out, chroma_u_input_sel_out,
    chroma_v_input_sel_out} inside {18'h01210, 18'h02120})
    else $error("bad component triplet");
  a_auto_detect: assert property (
    !$stable(video_standard_choice_out) |-> std_auto_detect_out ==
    (video_standard_choice_out < 4'h4)) else $error("auto detect wrong");
  a_pal_n_pair: assert property (
    !$stable(video_standard_choice_out) |-> std_pal_n_pair_out ==
    (video_standard_choice_out[3:1] == 3'h1)) else $error("pairing wrong");
  a_pedestal_odd: assert property (
    !$stable(video_standard_choice_out) |-> pedestal_out ==
    (video_standard_choice_out[0] && video_standard_choice_out <= 4'hd))
    else $error("pedestal wrong");
  a_fsc_ntsc_only: assert property (
    four_subcarrier_rate_mode_out |-> video_standard_choice_out <= 4'h7)
    else $error("fsc mode outside ntsc");
  a_reacq_single: assert property (
    reacquire_pulse_out |=> !reacquire_pulse_out) else $error("long pulse");
  a_core_levels: assert property (
    luma_core_threshold_out inside {6'h00, 6'h08, 6'h10, 6'h20})
    else $error("bad coring level");
  c_reacq: cover property (reacquire_pulse_out);
  c_comp: cover property (input_format_out == 2'h2);
  c_fsc: cover property (four_subcarrier_rate_mode_out);
endmodule // vicr_regs_asserts

bind vicr_regs vicr_regs_asserts u_chk (.*);

// file: verification/vicr_host.sv
// Host model that programs the register bank over AXI4-Lite.
`timescale 1ns/10ps
// ===================================================================
// Host
module vicr_host (
  input  wire        clk_in,
  output reg  [7:0]  s_axi_awaddr_in,
  output reg         s_axi_awvalid_in,
  input  wire        s_axi_awready_out,
  output reg  [31:0] s_axi_wdata_in,
  output reg  [3:0]  s_axi_wstrb_in,
  output reg         s_axi_wvalid_in,
  input  wire        s_axi_wready_out,
  input  wire [1:0]  s_axi_bresp_out,
  input  wire        s_axi_bvalid_out,
  output reg         s_axi_bready_in,
  output reg  [7:0]  s_axi_araddr_in,
  output reg         s_axi_arvalid_in,
  input  wire        s_axi_arready_out,
  input  wire [31:0] s_axi_rdata_out,
  input  wire [1:0]  s_axi_rresp_out,
  input  wire        s_axi_rvalid_out,
  output reg         s_axi_rready_in
);
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_wstrb_in} = 6'h00;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
  end
  // Released lines flip, so a slave cannot live off a stale value.
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    begin
      @(posedge clk_in);
      {s_axi_awaddr_in, s_axi_wdata_in, s_axi_wstrb_in} <= {a, d, s};
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
      do begin
        @(posedge clk_in);
        if (s_axi_awvalid_in && s_axi_awready_out) begin
          {s_axi_awvalid_in, s_axi_awaddr_in} <= {1'b0, ~a};
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
          {s_axi_wvalid_in, s_axi_wdata_in} <= {1'b0, ~d};
        end
      end while (!s_axi_bvalid_out);
      r = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge clk_in);
      {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {a, 2'h3};
      do begin
        @(posedge clk_in);
        if (s_axi_arvalid_in && s_axi_arready_out) begin
          {s_axi_arvalid_in, s_axi_araddr_in} <= {1'b0, ~a};
        end
      end while (!s_axi_rvalid_out);
      {d, r} = {s_axi_rdata_out, s_axi_rresp_out};
      s_axi_rready_in <= 1'b0;
    end
  endtask
endmodule // vicr_host

// file: verification/vicr_regs_bench.sv
// Self-checking bench for the video input configuration register bank.
`timescale 1ns/10ps
// ===================================================================
// Bench
module vicr_regs_bench;
  reg         clk_in = 1'b0;
  reg         resetn_in = 1'b0;
  wire [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  wire [31:0] s_axi_wdata_in, s_axi_rdata_out;
  wire [3:0]  s_axi_wstrb_in, video_standard_choice_out;
  wire [1:0]  s_axi_bresp_out, s_axi_rresp_out, input_format_out;
  wire [1:0]  source_quality_class_out;
  wire        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  wire        s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  wire        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  wire        s_axi_rready_in, std_auto_detect_out, std_pal_n_pair_out;
  wire        pedestal_out, four_subcarrier_rate_mode_out;
  wire        reacquire_pulse_out, square_pixel_enable_out;
  wire        differential_input_enable_out, studio_input_enable_out;
  wire [5:0]  luma_input_sel_out, chroma_u_input_sel_out;
  wire [5:0]  chroma_v_input_sel_out, luma_core_threshold_out;
  wire [2:0]  luma_peaking_gain_out;
  wire [19:0] route_view = {input_format_out, chroma_v_input_sel_out,
                            chroma_u_input_sel_out, luma_input_sel_out};
  integer     pulses = 0;
  integer     failures = 0;
  integer     total_checks = 0;
  integer     i;
  reg [31:0]  rv;
  reg [1:0]   rr;
  vicr_regs dut (.*);
  vicr_host host (.*);
  always #10 clk_in = ~clk_in;
  // A pulse is counted at the edge after the one that launches it.
  always @(posedge clk_in) begin
    if (reacquire_pulse_out === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Outputs lag the register by one clock, so settle before judging.
  task put(input [7:0] a, input [7:0] d);
    begin
      host.wr(a, {24'h0, d}, 4'h1, rr);
      repeat (2) @(posedge clk_in);
    end
  endtask
  function [19:0] rexp(input [3:0] c);
    begin
      if (c < 4'h6) rexp = {14'h0, 6'h01 << c};
      else if (c < 4'h9) rexp = {8'h40, 6'h08 << (c - 6), 6'h01 << (c - 6)};
      else if (c == 4'h9) rexp = 20'h90201;
      else if (c == 4'ha) rexp = 20'ha0102;
      else rexp = 20'hc0000;
    end
  endfunction
  task t_route;
    begin
      host.rd(8'h08, rv, rr);
      chk("enh reset", rv, 32'h04);
      chk("peaking reset", luma_peaking_gain_out, 3'h4);
      for (i = 0; i < 12; i = i + 1) begin
        put(8'h00, i[7:0]);
        chk("route", route_view, rexp(i[3:0]));
      end
      put(8'h04, 8'h80);
      put(8'h00, 8'h02);
      put(8'h04, 8'h00);
      put(8'h00, 8'h02);
      put(8'h00, 8'h03);
      host.rd(8'h0c, rv, rr);
      chk("reacquire count", rv[7:0], 8'd12);
      chk("reacquire pulses", pulses, 12);
    end
  endtask
  task t_std;
    begin
      for (i = 0; i < 14; i = i + 1) begin
        put(8'h00, {i[3:0], 4'h3});
        chk("standard", {video_standard_choice_out, std_auto_detect_out,
          std_pal_n_pair_out, pedestal_out},
          {i[3:0], i < 4, i == 2 || i == 3, i[0]});
      end
      put(8'h04, 8'h10);
      put(8'h00, 8'h43);
      chk("fsc ntsc", four_subcarrier_rate_mode_out, 1);
      put(8'h00, 8'h83);
      chk("fsc pal", four_subcarrier_rate_mode_out, 0);
    end
  endtask
  task mode(input [7:0] d, input [5:0] e);
    begin
      put(8'h04, d);
      chk("mode", {source_quality_class_out, square_pixel_enable_out,
        differential_input_enable_out, four_subcarrier_rate_mode_out,
        studio_input_enable_out}, e);
    end
  endtask
  task t_mode;
    begin
      mode(8'h2f, 6'h3d);
      mode(8'h12, 6'h20);
      mode(8'h01, 6'h10);
      host.rd(8'h04, rv, rr);
      chk("mode read", rv, 32'h01);
      chk("mode read resp", rr, 2'h0);
    end
  endtask
  task t_enh;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        put(8'h08, {3'h0, i[1:0], i[2:0]});
        chk("peaking", luma_peaking_gain_out, i[2:0]);
        chk("coring", luma_core_threshold_out,
          (i[1:0] == 2'h0) ? 0 : (6'h04 << i[1:0]));
      end
    end
  endtask
  task t_refuse;
    begin
      host.wr(8'h10, 32'h5a, 4'h1, rr);
      chk("unmapped write", rr, 2'h2);
      host.rd(8'h10, rv, rr);
      chk("unmapped read", rv, 32'h00000000);
      chk("unmapped read resp", rr, 2'h2);
      host.wr(8'h08, 32'hff, 4'h0, rr);
      host.rd(8'h08, rv, rr);
      chk("masked write", rv, 32'h1f);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_route;
    t_std;
    t_mode;
    t_enh;
    t_refuse;
    close_out;
  end
  initial begin
    repeat (6000) @(posedge clk_in);
    failures = failures + 1;
    close_out;
  end
endmodule // vicr_regs_bench
